// ---- common/pgseq_alu_if.sv ----
// link between the sequencer and its 8-bit alu
`timescale 1ns/1ns
`default_nettype none
interface pgseq_alu_if;
  import pgseq_pkg::*;
  logic [7:0] a;
  logic [7:0] m;
  pgseq_flags_type fl_in;
  pgseq_fn_type fn;
  logic [7:0] res;
  pgseq_flags_type fl_out;
  pgseq_flags_type upd;
  modport seq (output a, m, fl_in, fn, input res, fl_out, upd);
  modport alu (input a, m, fl_in, fn, output res, fl_out, upd);
endinterface : pgseq_alu_if
`default_nettype wire

// ---- common/pgseq_cfg.svh ----
// constants of the program sequencer: offsets, fields, resets, sizes
`ifndef PGSEQ_CFG_SVH
`define PGSEQ_CFG_SVH

// program counter width and vectors
`define PGSEQ_PC_W 12
`define PGSEQ_RST_VEC 12'h000
`define PGSEQ_IRQ_VEC 12'h004
`define PGSEQ_PAGE_LSB 8

// return stack
`define PGSEQ_STK_DEPTH 8

// instruction word fields
`define PGSEQ_OP_LSB 12
`define PGSEQ_FN_LSB 8

// data-space address at which the pc low byte appears
`define PGSEQ_PCL_DM 8'h02

// wishbone register byte offsets
`define PGSEQ_ADR_PCL 8'h00
`define PGSEQ_ADR_CTRL 8'h04
`define PGSEQ_ADR_STAT 8'h08

// control register bits and reset values
`define PGSEQ_CTRL_RUN 0
`define PGSEQ_CTRL_IEN 1
`define PGSEQ_RUN_RST 1'b1
`define PGSEQ_IEN_RST 1'b0

// status register fields
`define PGSEQ_ST_FLAGS 0
`define PGSEQ_ST_LVL 8
`define PGSEQ_ST_FULL 12
`define PGSEQ_ST_IRQF 16
`define PGSEQ_ST_ACC 24

`endif

// ---- common/pgseq_pkg.sv ----
// types shared by the program sequencer and its alu
package pgseq_pkg;

  // four phases of one instruction cycle, gray coded
  typedef enum logic [1:0] {
    PH_FETCH = 2'h0,
    PH_DEC = 2'h1,
    PH_EXE = 2'h3,
    PH_WB = 2'h2
  } pgseq_phase_type;

  // instruction opcodes, upper nibble of the word
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_JMP = 4'h1,
    OP_CALL = 4'h2,
    OP_RET = 4'h3,
    OP_INTERRUPT_RETURN_INSTR = 4'h4,
    OP_ALUA = 4'h5,
    OP_ALUM = 4'h6,
    OP_MOVI = 4'h7,
    OP_MOVM = 4'h8,
    OP_SZ = 4'h9,
    OP_SIZ = 4'hA,
    OP_SDZ = 4'hB,
    OP_RSV0 = 4'hC,
    OP_RSV1 = 4'hD,
    OP_RSV2 = 4'hE,
    OP_RSV3 = 4'hF
  } pgseq_op_type;

  // alu functions
  typedef enum logic [3:0] {
    FN_ADD = 4'h0,
    FN_ADC = 4'h1,
    FN_SUB = 4'h2,
    FN_SBC = 4'h3,
    FN_DAA = 4'h4,
    FN_AND = 4'h5,
    FN_OR = 4'h6,
    FN_XOR = 4'h7,
    FN_CPL = 4'h8,
    FN_RR = 4'h9,
    FN_RRC = 4'hA,
    FN_RL = 4'hB,
    FN_RLC = 4'hC,
    FN_INC = 4'hD,
    FN_DEC = 4'hE,
    FN_PASS = 4'hF
  } pgseq_fn_type;

  // status flags, carry in bit 0
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } pgseq_flags_type;

endpackage : pgseq_pkg

// ---- src/pgseq_alu.sv ----
// 8-bit alu: arithmetic, logic, rotate, inc/dec and zero test
`timescale 1ns/1ns
`default_nettype none
module pgseq_alu (
  pgseq_alu_if.alu x // operands in, result and flags out
);
  import pgseq_pkg::*;

  logic [7:0] b;
  logic ci;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] adj;

  // operand b and carry for add and subtract
  always_comb begin
    b = ((x.fn == FN_SUB) || (x.fn == FN_SBC)) ? ~x.m : x.m;
    unique case (x.fn)
      FN_ADC, FN_SBC: ci = x.fl_in.c;
      FN_SUB: ci = 1'b1;
      default: ci = 1'b0;
    endcase
    sum = {1'b0, x.a} + {1'b0, b} + {8'h00, ci};
    nib = {1'b0, x.a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    adj = 8'h00;
    if ((x.a[3:0] > 4'h9) || x.fl_in.ac) adj[3:0] = 4'h6;
    if ((x.a > 8'h99) || x.fl_in.c) adj[7:4] = 4'h6;
  end

  // result, new flags and which flags the function updates
  always_comb begin
    x.fl_out = x.fl_in;
    x.upd = '0;
    x.res = x.m;
    unique case (x.fn)
      FN_ADD, FN_ADC, FN_SUB, FN_SBC: begin
        x.res = sum[7:0];
        x.fl_out.c = sum[8];
        x.fl_out.ac = nib[4];
        x.fl_out.ov = (x.a[7] == b[7]) && (sum[7] != x.a[7]);
        x.upd = 4'hF;
      end
      FN_DAA: begin
        x.res = x.a + adj;
        x.fl_out.c = x.fl_in.c | (adj[7:4] != 4'h0);
        x.upd.c = 1'b1;
      end
      FN_AND: x.res = x.a & x.m;
      FN_OR: x.res = x.a | x.m;
      FN_XOR: x.res = x.a ^ x.m;
      FN_CPL: x.res = ~x.m;
      FN_RR: x.res = {x.m[0], x.m[7:1]};
      FN_RRC: begin
        x.res = {x.fl_in.c, x.m[7:1]};
        x.fl_out.c = x.m[0];
        x.upd.c = 1'b1;
      end
      FN_RL: x.res = {x.m[6:0], x.m[7]};
      FN_RLC: begin
        x.res = {x.m[6:0], x.fl_in.c};
        x.fl_out.c = x.m[7];
        x.upd.c = 1'b1;
      end
      FN_INC: x.res = x.m + 8'h01;
      FN_DEC: x.res = x.m - 8'h01;
      FN_PASS: x.res = x.m;
    endcase
    x.fl_out.z = (x.res == 8'h00);
    if ((x.fn != FN_RR) && (x.fn != FN_RRC) && (x.fn != FN_RL) && (x.fn != FN_RLC)) begin
      x.upd.z = 1'b1;
    end
  end
endmodule : pgseq_alu
`default_nettype wire

// ---- src/pgseq_top.sv ----
// program sequencer: phases, pipeline, program counter, stack, alu control
`timescale 1ns/1ns
`default_nettype none
`include "pgseq_cfg.svh"
module pgseq_top #(
  parameter int PC_W = `PGSEQ_PC_W, // program counter width
  parameter int DEPTH = `PGSEQ_STK_DEPTH, // return stack levels
  parameter logic [PC_W-1:0] IRQ_VEC = `PGSEQ_IRQ_VEC // interrupt entry address
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic srst, // synchronous reset, active high
  output logic [PC_W-1:0] pm_addr, // program memory address
  output logic pm_rd, // fetch strobe during fetch phase
  input wire logic [15:0] pm_data, // instruction word
  output logic [7:0] dm_addr, // data memory address
  input wire logic [7:0] dm_rdata, // data memory read data
  output logic [7:0] dm_wdata, // data memory write data
  output logic dm_we, // data memory write strobe
  input wire logic irq_req, // interrupt request pulse
  output logic irq_ack, // interrupt acknowledge pulse
  output logic [3:0] phase, // one-hot phase, bit 0 is fetch
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o // wishbone acknowledge
);
  import pgseq_pkg::*;

  // stack index width and level counter width; level counts up to depth
  localparam int SPW = $clog2(DEPTH);
  localparam int LVW = $clog2(DEPTH + 1);
  localparam logic [LVW-1:0] LV_FULL = LVW'(DEPTH);

  typedef struct packed {
    pgseq_phase_type ph;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] exec_pc;
    logic [15:0] fetch;
    logic [15:0] exec;
    logic exec_ok;
    logic [7:0] acc;
    logic [7:0] m;
    logic [7:0] dm_addr;
    logic [7:0] dm_wdata;
    logic dm_we;
    pgseq_flags_type fl;
    logic skip;
    logic pcl_jmp;
    logic [7:0] pcl_val;
    logic bus_pcl;
    logic [7:0] bus_val;
    logic [DEPTH-1:0][PC_W-1:0] stk;
    logic [SPW-1:0] sp;
    logic [LVW-1:0] lvl;
    logic irqf;
    logic ien;
    logic run;
    logic irq_ack;
    logic wb_ack;
    logic [31:0] wb_dat;
  } pgseq_state_type;

  pgseq_state_type s_q;
  pgseq_state_type s_d;

  // alu link and the alu itself, purely combinational

  pgseq_alu_if alu_x ();

  pgseq_alu u_alu (
    .x(alu_x)
  );

  // decode and control helpers, all driven by the next-state logic or assigns

  pgseq_op_type op;
  logic full;
  logic req;
  logic wr;
  logic redir;
  logic take_irq;
  logic [PC_W-1:0] tgt;
  logic [SPW-1:0] sp_dn;

  // decode of the executing word and stack state
  assign op = pgseq_op_type'(s_q.exec[`PGSEQ_OP_LSB +: 4]);
  assign full = (s_q.lvl == LV_FULL);
  assign sp_dn = s_q.sp - SPW'(1);
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & s_q.wb_ack & wb_we_i;

  // alu operands: accumulator and fetched data operand
  always_comb begin
    alu_x.a = s_q.acc;
    alu_x.m = s_q.m;
    alu_x.fl_in = s_q.fl;
    unique case (op)
      OP_SZ: alu_x.fn = FN_PASS;
      OP_SIZ: alu_x.fn = FN_INC;
      OP_SDZ: alu_x.fn = FN_DEC;
      default: alu_x.fn = pgseq_fn_type'(s_q.exec[`PGSEQ_FN_LSB +: 4]);
    endcase
  end

  // next state of the whole sequencer
  always_comb begin
    s_d = s_q;
    s_d.dm_we = 1'b0;
    s_d.irq_ack = 1'b0;
    redir = 1'b0;
    take_irq = 1'b0;
    tgt = '0;
    unique case (s_q.ph)
      PH_FETCH: begin
        // hold here while stopped; word sampled on leaving
        if (s_q.run) begin
          s_d.ph = PH_DEC;
          s_d.fetch = pm_data;
          s_d.dm_addr = s_q.exec[7:0];
        end
      end
      PH_DEC: begin
        // operand read; the pc low byte answers at its data address
        s_d.ph = PH_EXE;
        if (s_q.dm_addr == `PGSEQ_PCL_DM) begin
          s_d.m = s_q.exec_pc[7:0];
        end else begin
          s_d.m = dm_rdata;
        end
      end
      PH_EXE: begin
        // execute and commit results, flags and skip decision
        s_d.ph = PH_WB;
        if (s_q.exec_ok) begin
          unique case (op)
            // alu result goes to the accumulator
            OP_ALUA: begin
              s_d.acc = alu_x.res;
              s_d.fl = (s_q.fl & ~alu_x.upd) | (alu_x.fl_out & alu_x.upd);
            end
            // result, or the accumulator for a move, back to the operand; the pc low byte address jumps instead
            // of storing, and inc/dec skips take their zero test here
            OP_ALUM, OP_MOVM, OP_SIZ, OP_SDZ: begin
              if (op == OP_ALUM) begin
                s_d.fl = (s_q.fl & ~alu_x.upd) | (alu_x.fl_out & alu_x.upd);
              end
              if ((op == OP_SIZ) || (op == OP_SDZ)) begin
                s_d.skip = alu_x.fl_out.z;
              end
              if (s_q.dm_addr == `PGSEQ_PCL_DM) begin
                s_d.pcl_jmp = 1'b1;
                s_d.pcl_val = (op == OP_MOVM) ? s_q.acc : alu_x.res;
              end else begin
                s_d.dm_we = 1'b1;
                s_d.dm_wdata = (op == OP_MOVM) ? s_q.acc : alu_x.res;
              end
            end
            // immediate load and plain zero test
            OP_MOVI: s_d.acc = s_q.exec[7:0];
            OP_SZ: s_d.skip = alu_x.fl_out.z;
            default: ;
          endcase
        end
      end
      PH_WB: begin
        // instruction boundary: the prefetched word moves to execute
        s_d.ph = PH_FETCH;
        s_d.exec = s_q.fetch;
        s_d.exec_pc = s_q.pc;
        s_d.exec_ok = 1'b1;
        s_d.skip = 1'b0;
        s_d.pcl_jmp = 1'b0;
        if (s_q.exec_ok) begin
          unique case (op)
            // absolute jump within the program space
            OP_JMP: begin
              redir = 1'b1;
              tgt = s_q.exec[PC_W-1:0];
            end
            // call: push the return address; a full stack wraps and loses
            // its oldest entry while the level stays saturated
            OP_CALL: begin
              redir = 1'b1;
              tgt = s_q.exec[PC_W-1:0];
              s_d.stk[s_q.sp] = s_q.pc;
              s_d.sp = s_q.sp + SPW'(1);
              if (!full) begin
                s_d.lvl = s_q.lvl + LVW'(1);
              end
            end
            // return: pop; an empty stack wraps the pointer, level stays zero
            OP_RET, OP_INTERRUPT_RETURN_INSTR: begin
              redir = 1'b1;
              tgt = s_q.stk[sp_dn];
              s_d.sp = sp_dn;
              if (s_q.lvl != '0) begin
                s_d.lvl = s_q.lvl - LVW'(1);
              end
              if (op == OP_INTERRUPT_RETURN_INSTR) begin
                s_d.ien = 1'b1;
              end
            end
            // taken skip drops the next word; a data-space low-byte write jumps
            default: begin
              if (s_q.skip) begin
                s_d.exec_ok = 1'b0;
              end else if (s_q.pcl_jmp) begin
                redir = 1'b1;
                tgt = {s_q.exec_pc[PC_W-1:`PGSEQ_PAGE_LSB], s_q.pcl_val};
              end
            end
          endcase
        end
        // bus write of the low byte, taken when nothing else redirects
        if (!redir && s_q.bus_pcl) begin
          redir = 1'b1;
          tgt = {s_q.exec_pc[PC_W-1:`PGSEQ_PAGE_LSB], s_q.bus_val};
          s_d.bus_pcl = 1'b0;
        end
        // interrupt entry is withheld while the stack is full
        if (!redir && !(s_q.exec_ok && s_q.skip) && s_q.irqf && s_q.ien && !full) begin
          take_irq = 1'b1;
          redir = 1'b1;
          tgt = IRQ_VEC;
          s_d.stk[s_q.sp] = s_q.pc;
          s_d.sp = s_q.sp + SPW'(1);
          s_d.lvl = s_q.lvl + LVW'(1);
          s_d.ien = 1'b0;
          s_d.irq_ack = 1'b1;
        end
        // a redirect throws away the prefetched word: dummy cycle
        if (redir) begin
          s_d.exec_ok = 1'b0;
          s_d.pc = tgt;
        end else begin
          s_d.pc = s_q.pc + PC_W'(1);
        end
      end
    endcase
    // request flag: a new request wins over the clear by entry
    s_d.irqf = irq_req | (s_q.irqf & ~take_irq);
    // wishbone: one-cycle registered answer, write at the ack edge
    s_d.wb_ack = req & ~s_q.wb_ack;

    // read mux, cleared first so unmapped offsets read zero
    if (req && !s_q.wb_ack) begin
      s_d.wb_dat = '0;
      unique case (wb_adr_i)
        `PGSEQ_ADR_PCL: s_d.wb_dat[7:0] = s_q.exec_pc[7:0];
        `PGSEQ_ADR_CTRL: begin
          s_d.wb_dat[`PGSEQ_CTRL_RUN] = s_q.run;
          s_d.wb_dat[`PGSEQ_CTRL_IEN] = s_q.ien;
        end
        `PGSEQ_ADR_STAT: begin
          s_d.wb_dat[`PGSEQ_ST_FLAGS +: 4] = s_q.fl;
          s_d.wb_dat[`PGSEQ_ST_LVL +: 4] = 4'(s_q.lvl);
          s_d.wb_dat[`PGSEQ_ST_FULL] = full;
          s_d.wb_dat[`PGSEQ_ST_IRQF] = s_q.irqf;
          s_d.wb_dat[`PGSEQ_ST_ACC +: 8] = s_q.acc;
        end
        default: ;
      endcase
    end

    // register writes act at the ack edge; hardware updates of the enable win
    if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == `PGSEQ_ADR_PCL) begin
        s_d.bus_pcl = 1'b1;
        s_d.bus_val = wb_dat_i[7:0];
      end else if (wb_adr_i == `PGSEQ_ADR_CTRL) begin
        s_d.run = wb_dat_i[`PGSEQ_CTRL_RUN];
        if (!(s_q.ph == PH_WB && (take_irq || (s_q.exec_ok && op == OP_INTERRUPT_RETURN_INSTR)))) begin
          s_d.ien = wb_dat_i[`PGSEQ_CTRL_IEN];
        end
      end
    end
  end

  // state register; reset starts at address zero, stack empty
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.ph <= PH_FETCH;
      s_q.pc <= `PGSEQ_RST_VEC;
      s_q.sp <= '0;
      s_q.lvl <= '0;
      s_q.run <= `PGSEQ_RUN_RST;
      s_q.ien <= `PGSEQ_IEN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign pm_addr = s_q.pc;
  assign pm_rd = (s_q.ph == PH_FETCH) & s_q.run;
  assign dm_addr = s_q.dm_addr;
  assign dm_wdata = s_q.dm_wdata;
  assign dm_we = s_q.dm_we;
  assign irq_ack = s_q.irq_ack;

  // one-hot phase pins, one bit per phase code, fetch in bit 0
  localparam pgseq_phase_type PH_OF_BIT [4] = '{PH_FETCH, PH_DEC, PH_EXE, PH_WB};
  for (genvar gi = 0; gi < 4; gi++) begin : g_phase
    assign phase[gi] = (s_q.ph == PH_OF_BIT[gi]);
  end

  // bus answer straight from the state register
  assign wb_dat_o = s_q.wb_dat;
  assign wb_ack_o = s_q.wb_ack;
endmodule : pgseq_top
`default_nettype wire

// ---- verification/pgseq_monitor.sv ----
// concurrent checks on the program sequencer top ports
`timescale 1ns/1ns
`default_nettype none
module pgseq_monitor #(
  parameter int PC_W = 12, // program counter width
  parameter logic [PC_W-1:0] IRQ_VEC = 12'h004 // interrupt entry
) (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic [PC_W-1:0] pm_addr, // fetch address
  input wire logic pm_rd, // fetch strobe
  input wire logic [3:0] phase, // one-hot phase
  input wire logic dm_we, // data write
  input wire logic irq_ack, // interrupt acknowledge
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o // bus acknowledge
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // decode, execute and writeback steps
  sequence s_exec;
    phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8;
  endsequence
  // fetch from the interrupt entry
  sequence s_vec;
    phase == 4'h1 && pm_addr == IRQ_VEC;
  endsequence
  chk_phase_onehot: assert property ($onehot(phase))
    else $error("phase not one-hot");
  chk_phase_order: assert property (phase == 4'h2 |-> s_exec ##1 phase == 4'h1)
    else $error("phase order broken");
  chk_fetch_strobe: assert property (pm_rd |-> phase == 4'h1)
    else $error("fetch outside fetch phase");
  chk_addr_hold: assert property (!phase[0] |-> $stable(pm_addr))
    else $error("pc moved outside fetch phase");
  chk_reset_start: assert property ($fell(srst) |-> pm_addr == '0 ##4 pm_addr == 1)
    else $error("no start from address zero");
  chk_store_slot: assert property (dm_we |-> phase == 4'h8 ##1 !dm_we)
    else $error("store outside writeback");
  chk_irq_entry: assert property (irq_ack |-> ##[0:8] s_vec)
    else $error("no fetch from interrupt entry");
  chk_irq_pulse: assert property ($rose(irq_ack) |=> !irq_ack [*3])
    else $error("acknowledge too long");
  chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer late");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
endmodule : pgseq_monitor
bind pgseq_top pgseq_monitor #(.PC_W(PC_W), .IRQ_VEC(IRQ_VEC)) pgseq_monitor_inst (
  .clk(clk), .srst(srst), .pm_addr(pm_addr), .pm_rd(pm_rd), .phase(phase), .dm_we(dm_we),
  .irq_ack(irq_ack), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ---- verification/pgseq_pmem.sv ----
// program memory model answering the sequencer fetches
`timescale 1ns/1ns
`default_nettype none
module pgseq_pmem (
  input wire logic [11:0] pm_addr, // fetch address
  input wire logic pm_rd, // fetch strobe
  output logic [15:0] pm_data // instruction word
);
  logic [15:0] mem [0:4095];
  // idle bus shows the inverted word, never a stale copy
  assign pm_data = pm_rd ? mem[pm_addr] : ~mem[pm_addr];
endmodule : pgseq_pmem
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench of the program sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pgseq_pkg::*;
  localparam logic [11:0] IRQ_V = 12'h0F0;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic irq_req = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [11:0] pm_addr;
  logic [15:0] pm_data;
  logic [7:0] dm_addr, dm_wdata, dm_rdata;
  logic [3:0] phase;
  logic pm_rd, dm_we, irq_ack, wb_ack_o;
  logic [7:0] dmem [0:255];
  logic [7:0] e_a[$], e_d[$], w_a[$], w_d[$];
  int e_g[$], w_t[$];
  int n_mismatch = 0, checked = 0, cyc_n = 0, n_ack = 0;
  pgseq_fn_type fl [10] = '{FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_CPL, FN_INC, FN_DEC,
    FN_RL, FN_RR};
  pgseq_top #(.IRQ_VEC(IRQ_V)) pgseq_top_inst (.clk(clk), .srst(srst), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .dm_addr(dm_addr), .dm_rdata(dm_rdata),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .irq_req(irq_req), .irq_ack(irq_ack), .phase(phase),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  pgseq_pmem pgseq_pmem_inst (.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));
  // clock and combinational data memory
  always #4 clk = ~clk;
  assign dm_rdata = dmem[dm_addr];
  // store into data memory and log each store with its cycle
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (irq_ack === 1'b1) n_ack <= n_ack + 1;
    if (dm_we === 1'b1) begin
      dmem[dm_addr] <= dm_wdata;
      w_a.push_back(dm_addr);
      w_d.push_back(dm_wdata);
      w_t.push_back(cyc_n);
    end
  end
  function automatic logic [7:0] alu_exp(input pgseq_fn_type f, input logic [7:0] a,
    input logic [7:0] m);
    case (f)
      FN_ADD: return a + m;
      FN_SUB: return a - m;
      FN_AND: return a & m;
      FN_OR: return a | m;
      FN_XOR: return a ^ m;
      FN_CPL: return ~m;
      FN_INC: return m + 8'h01;
      FN_DEC: return m - 8'h01;
      FN_RL: return {m[6:0], m[7]};
      default: return {m[0], m[7:1]};
    endcase
  endfunction : alu_exp
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // ack and read data are taken as they stood at the edge, before it updates them
    @(posedge clk iff (wb_ack_o === 1'b1));
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic put(input logic [11:0] a, input logic [3:0] op, input logic [11:0] arg);
    pgseq_pmem_inst.mem[a] = {op, arg};
  endtask : put
  // store instruction plus the store it should produce
  task automatic st(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v, input int g);
    put(a, OP_MOVM, {4'h0, m});
    e_a.push_back(m);
    e_d.push_back(v);
    e_g.push_back(g);
  endtask : st
  task automatic wait_w(input int n);
    repeat (3000) if (w_a.size() < n) @(posedge clk);
  endtask : wait_w
  task automatic report_and_stop;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  // program build, run and comparisons
  initial begin
    logic [31:0] q;
    logic [7:0] a, dv, r;
    int s;
    s = $urandom(32'hFEF9E0E5);
    foreach (dmem[i]) dmem[i] = 8'h00;
    for (int i = 0; i < 4096; i++) put(12'(i), OP_NOP, 12'h000);
    dv = 8'($urandom);
    dmem[8'h10] = dv;
    for (int i = 0; i < 10; i++) begin
      a = 8'($urandom);
      r = alu_exp(fl[i], a, dv);
      put(12'(3 * i), OP_MOVI, {4'h0, a});
      put(12'(3 * i + 1), OP_ALUA, {fl[i], 8'h10});
      st(12'(3 * i + 2), 8'h20 + 8'(i), r, (i == 0) ? 0 : 12);
    end
    put(12'h01E, OP_JMP, 12'h040);
    put(12'h01F, OP_MOVM, 12'h03F);
    st(12'h040, 8'h31, r, 12);
    put(12'h041, OP_CALL, 12'h080);
    st(12'h080, 8'h32, r, 12);
    put(12'h081, OP_RET, 12'h000);
    st(12'h042, 8'h33, r, 12);
    put(12'h043, OP_SZ, 12'h012);
    put(12'h044, OP_MOVM, 12'h03E);
    st(12'h045, 8'h34, r, 12);
    put(12'h046, OP_JMP, 12'h146);
    put(12'h146, OP_MOVI, 12'h060);
    put(12'h147, OP_MOVM, 12'h002);
    put(12'h148, OP_MOVM, 12'h03D);
    st(12'h160, 8'h35, 8'h60, 24);
    put(12'h162, OP_JMP, 12'h161);
    st(IRQ_V, 8'h36, 8'h60, 0);
    put(IRQ_V + 12'h001, OP_INTERRUPT_RETURN_INSTR, 12'h000);
    repeat (8) @(posedge clk);
    chk("reset pm_addr", 32'h0, 32'(pm_addr));
    chk("reset phase", 32'h1, 32'(phase));
    srst <= 1'b0;
    wb(1'b0, 8'h08, 32'h0, q);
    chk("stack level", 32'h0, q & 32'h1F00);
    wb(1'b0, 8'h00, 32'h0, q);
    chk("pc upper hidden", 32'h0, q & 32'hFFFFFF00);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wait_w(15);
    wb(1'b1, 8'h04, 32'h3, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("ctrl", 32'h3, q);
    irq_req <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    wait_w(16);
    repeat (8) @(posedge clk);
    chk("irq acks", 32'h1, 32'(n_ack));
    wb(1'b0, 8'h08, 32'h0, q);
    chk("status after isr", 32'h60000000, q & 32'hFF011F00);
    chk("store count", 32'(e_a.size()), 32'(w_a.size()));
    foreach (e_a[i]) if (i < w_a.size()) begin
      chk("store addr", 32'(e_a[i]), 32'(w_a[i]));
      chk("store data", 32'(e_d[i]), 32'(w_d[i]));
      if (e_g[i] != 0) chk("store gap", 32'(e_g[i]), 32'(w_t[i] - w_t[i - 1]));
    end
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
